// ### src/sysctl_bank.sv
// Purpose: control register and cachable-area registers of the core
// Assumes: straps stable around reset release; requests held until ack
// Notes: one transfer per two cycles; ack is a one-cycle pulse
`timescale 1ns/1ps
// How it works
// - software writes reserved fields legally or preserves
// - reserved control bits read unpredictable values
// - instruction memory load mode, resets clear
// - instruction memory enable, reset from strap
// - data memory load mode, resets clear
// - data memory enable, priority, resets clear
// - load state switch disable, resets clear
// - replacement select round-robin or random, resets clear
// - vector base zero or high page
// - alternate vector from strap, then writable
// - instruction cache needs enable and protection
// - no instruction cache enable without cache
// - endian bit big when set, resets clear
// - data cache needs enable and protection
// - no data cache enable without cache
// - protection clear disables caches, write buffer
// - program a region before enabling protection
// - selector picks data or instruction areas
// - eight cachable bits, one per area
module sysctl_bank
  import sysctl_pkg::*;
(
  input  wire logic mclk,
  input  wire logic rst,
  input  wire logic clk_en,
  input  wire logic instr_mem_init_strap,
  input  wire logic high_vector_strap,
  sysctl_if.bank    link,
  output logic      imem_load_mode,
  output logic      imem_enable,
  output logic      dmem_load_mode,
  output logic      dmem_enable,
  output logic      load_state_switch_dis,
  output logic      round_robin,
  output word_t     vector_base,
  output logic      icache_on,
  output logic      big_endian,
  output logic      dcache_on,
  output logic      prot_on,
  output logic      write_buffer_on,
  output areas_t    data_cachable_areas,
  output areas_t    instr_cachable_areas
);
`include "sysctl_defines.svh"

  typedef struct packed {
    logic   strap_pend;
    word_t  system_control;
    areas_t data_areas;
    areas_t instr_areas;
    logic   ack;
    word_t  rdata;
    logic   icache_on;
    logic   dcache_on;
    logic   wb_on;
    word_t  vbase;
  } bank_state_t;

  bank_state_t s_q;
  bank_state_t s_d;
  word_t       ctrl_n;
  word_t       rd_word;
  logic        take;

  // decode used for both read and write paths
  function automatic logic is_areas(input logic [3:0] r,
                                    input logic [2:0] sel,
                                    input logic [2:0] want);
    return (r == `REG_CACHABLE_AREAS) && (sel == want);
  endfunction

  // reserved control bits are not stored
  function automatic word_t ctrl_store(input word_t v);
    return v & `CTRL_WRITE_MASK;
  endfunction

  // a cache runs only with its own enable and protection enable
  function automatic logic cache_gate(input word_t c,
                                      input logic  enable_bit);
    return enable_bit & c[`BIT_PROT_ENABLE];
  endfunction

  function automatic word_t areas_word(input areas_t a);
    return {24'h00_0000, a};
  endfunction

  // unmapped numbers and selectors read as zero
  function automatic word_t read_mux(input logic [3:0] r,
                                     input logic [2:0] sel,
                                     input word_t      ctrl,
                                     input areas_t     da,
                                     input areas_t     ia);
    word_t v;
    v = 32'h0000_0000;
    case (r)
      `REG_SYSTEM_CONTROL: begin
        // reserved one-bits read as set; treat as unpredictable
        v = ctrl | `CTRL_SBO_VALUE;
      end
      `REG_CACHABLE_AREAS: begin
        if (is_areas(r, sel, `SEL_DATA_AREAS)) begin
          v = areas_word(da);
        end else if (is_areas(r, sel, `SEL_INSTR_AREAS)) begin
          v = areas_word(ia);
        end else begin
          v = 32'h0000_0000;
        end
      end
      default: begin
        v = 32'h0000_0000;
      end
    endcase
    return v;
  endfunction

  always_comb begin
    s_d     = s_q;
    s_d.ack = 1'b0;
    ctrl_n  = s_q.system_control;
    take    = link.req && !s_q.ack;
    rd_word = read_mux(link.reg_num, link.sel, s_q.system_control,
                       s_q.data_areas, s_q.instr_areas);
    // straps caught by a clocked load just after reset release
    if (s_q.strap_pend) begin
      ctrl_n[`BIT_IMEM_ENABLE] = instr_mem_init_strap;
      ctrl_n[`BIT_ALT_VECTOR]  = high_vector_strap;
      s_d.strap_pend           = 1'b0;
    end
    // ack high blocks retaking the request still held on the ack edge
    if (take) begin
      s_d.ack = 1'b1;
      if (link.wr) begin
        case (link.reg_num)
          `REG_SYSTEM_CONTROL: begin
            ctrl_n = ctrl_store(link.wdata);
          end
          `REG_CACHABLE_AREAS: begin
            if (is_areas(link.reg_num, link.sel, `SEL_DATA_AREAS)) begin
              s_d.data_areas = link.wdata[7:0];
            end
            if (is_areas(link.reg_num, link.sel, `SEL_INSTR_AREAS)) begin
              s_d.instr_areas = link.wdata[7:0];
            end
          end
          default: begin
            // writes to unmapped numbers are dropped
          end
        endcase
      end else begin
        // read data then holds until the next read
        s_d.rdata = rd_word;
      end
    end
    s_d.system_control = ctrl_n;
    // a write setting cache and protection together takes effect at once
    s_d.icache_on = cache_gate(ctrl_n,
                               ctrl_n[`BIT_ICACHE_ENABLE]);
    s_d.dcache_on = cache_gate(ctrl_n,
                               ctrl_n[`BIT_DCACHE_ENABLE]);
    s_d.wb_on     = ctrl_n[`BIT_PROT_ENABLE];
    // registered so the vector base output comes from a flip-flop
    s_d.vbase     = ctrl_n[`BIT_ALT_VECTOR] ? `VECTOR_BASE_HIGH
                                            : `VECTOR_BASE_LOW;
  end

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      // async branch loads constants only; straps follow one edge later
      s_q <= '0;
      s_q.strap_pend <= 1'b1;
      s_q.system_control <= `CTRL_RESET_VALUE;
      s_q.data_areas <= `AREAS_RESET_VALUE;
      s_q.instr_areas <= `AREAS_RESET_VALUE;
      // protection off at reset: caches and write buffer off too
      s_q.icache_on <= 1'b0;
      s_q.dcache_on <= 1'b0;
      s_q.wb_on <= 1'b0;
      s_q.vbase <= `VECTOR_BASE_LOW;
    end else if (clk_en) begin
      s_q <= s_d;
    end
  end

  assign link.ack              = s_q.ack;
  assign link.rdata            = s_q.rdata;
  assign imem_load_mode        = s_q.system_control[`BIT_IMEM_LOAD_MODE];
  assign imem_enable           = s_q.system_control[`BIT_IMEM_ENABLE];
  assign dmem_load_mode        = s_q.system_control[`BIT_DMEM_LOAD_MODE];
  assign dmem_enable           = s_q.system_control[`BIT_DMEM_ENABLE];
  assign load_state_switch_dis =
    s_q.system_control[`BIT_LOAD_SWITCH_DIS];
  assign round_robin = s_q.system_control[`BIT_ROUND_ROBIN];
  assign vector_base           = s_q.vbase;
  assign icache_on             = s_q.icache_on;
  assign big_endian            = s_q.system_control[`BIT_BIG_ENDIAN];
  assign dcache_on             = s_q.dcache_on;
  assign prot_on               = s_q.system_control[`BIT_PROT_ENABLE];
  assign write_buffer_on       = s_q.wb_on;
  assign data_cachable_areas   = s_q.data_areas;
  assign instr_cachable_areas  = s_q.instr_areas;
endmodule

// ### src/sysctl_defines.svh
// Purpose: constants for the system control register bank
// Assumes: included by bare name from the bank and core-end modules
// Notes: register numbers follow the coprocessor register selector
`ifndef SYSCTL_DEFINES_SVH
`define SYSCTL_DEFINES_SVH

`define REG_SYSTEM_CONTROL   4'h1
`define REG_CACHABLE_AREAS   4'h2
`define SEL_DATA_AREAS       3'h0
`define SEL_INSTR_AREAS      3'h1

`define BIT_IMEM_LOAD_MODE   19
`define BIT_IMEM_ENABLE      18
`define BIT_DMEM_LOAD_MODE   17
`define BIT_DMEM_ENABLE      16
`define BIT_LOAD_SWITCH_DIS  15
`define BIT_ROUND_ROBIN      14
`define BIT_ALT_VECTOR       13
`define BIT_ICACHE_ENABLE    12
`define BIT_BIG_ENDIAN       7
`define BIT_DCACHE_ENABLE    2
`define BIT_PROT_ENABLE      0

// writable bits; everything else is reserved
`define CTRL_WRITE_MASK      32'h000F_F085
// reserved one-bits as returned on read
`define CTRL_SBO_VALUE       32'h0000_0078
`define CTRL_RESET_VALUE     32'h0000_0000
`define AREAS_RESET_VALUE    8'h00

`define VECTOR_BASE_LOW      32'h0000_0000
`define VECTOR_BASE_HIGH     32'hFFFF_0000

`endif

// ### src/sysctl_pkg.sv
// Purpose: types for the system control register bank
// Assumes: nothing
// Notes: constants live in sysctl_defines.svh
package sysctl_pkg;
  typedef logic [31:0] word_t;
  typedef logic [7:0]  areas_t;
  typedef enum logic [1:0] {
    XFER_IDLE,
    XFER_WAIT
  } xfer_state_t;
endpackage

// ### src/sysctl_if.sv
// Purpose: coprocessor register transfer link between core and bank
// Assumes: one clock, mclk, shared by both ends
// Notes: request held until ack; one transfer outstanding
`timescale 1ns/1ps
interface sysctl_if
  import sysctl_pkg::*;
  ();
  logic       req;
  logic       wr;
  logic [3:0] reg_num;
  logic [2:0] sel;
  word_t      wdata;
  logic       ack;
  word_t      rdata;

  modport core (output req, output wr, output reg_num, output sel,
                output wdata, input ack, input rdata);
  modport bank (input req, input wr, input reg_num, input sel,
                input wdata, output ack, output rdata);
endinterface

// ### src/sysctl_core_end.sv
// Purpose: core-side end issuing register transfers to the bank
// Assumes: user holds cmd fields stable while cmd_valid and not ready
// Notes: keeps reserved fields legal and guards cache enables
`timescale 1ns/1ps
module sysctl_core_end
  import sysctl_pkg::*;
#(
  parameter bit HAS_ICACHE = 1'b1,
  parameter bit HAS_DCACHE = 1'b1
) (
  input  wire logic       mclk,
  input  wire logic       rst,
  input  wire logic       clk_en,
  input  wire logic       cmd_valid,
  input  wire logic       cmd_wr,
  input  wire logic [3:0] cmd_reg,
  input  wire logic [2:0] cmd_sel,
  input  wire word_t      cmd_wdata,
  input  wire logic       region_programmed,
  output logic            cmd_ready,
  output logic            rsp_valid,
  output word_t           rsp_data,
  sysctl_if.core          link
);
`include "sysctl_defines.svh"

  typedef struct packed {
    xfer_state_t st;
    logic        req;
    logic        wr;
    logic [3:0]  reg_num;
    logic [2:0]  sel;
    word_t       wdata;
    logic        ready;
    logic        rvalid;
    word_t       rdata;
  } core_state_t;

  core_state_t s_q, s_d;

  function automatic word_t legalise(input word_t v);
    word_t r;
    r = (v & `CTRL_WRITE_MASK) | `CTRL_SBO_VALUE;
    if (!HAS_ICACHE) r[`BIT_ICACHE_ENABLE] = 1'b0;
    if (!HAS_DCACHE) r[`BIT_DCACHE_ENABLE] = 1'b0;
    // no protection enable until a region is set up
    if (!region_programmed) r[`BIT_PROT_ENABLE] = 1'b0;
    return r;
  endfunction

  always_comb begin
    s_d = s_q;
    s_d.rvalid = 1'b0;
    case (s_q.st)
      XFER_IDLE: begin
        s_d.ready = 1'b1;
        if (cmd_valid && s_q.ready) begin
          s_d.st      = XFER_WAIT;
          s_d.req     = 1'b1;
          s_d.ready   = 1'b0;
          s_d.wr      = cmd_wr;
          s_d.reg_num = cmd_reg;
          s_d.sel     = cmd_sel;
          s_d.wdata   = (cmd_reg == `REG_SYSTEM_CONTROL) ?
                        legalise(cmd_wdata) : cmd_wdata;
        end
      end
      XFER_WAIT: begin
        if (link.ack) begin
          s_d.st     = XFER_IDLE;
          s_d.req    = 1'b0;
          s_d.ready  = 1'b1;
          s_d.rvalid = ~s_q.wr;
          s_d.rdata  = link.rdata;
        end
      end
      default: s_d.st = XFER_IDLE;
    endcase
  end

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      s_q <= '0;
    end else if (clk_en) begin
      s_q <= s_d;
    end
  end

  assign link.req     = s_q.req;
  assign link.wr      = s_q.wr;
  assign link.reg_num = s_q.reg_num;
  assign link.sel     = s_q.sel;
  assign link.wdata   = s_q.wdata;
  assign cmd_ready    = s_q.ready;
  assign rsp_valid    = s_q.rvalid;
  assign rsp_data     = s_q.rdata;
endmodule

// ### verif/sysctl_monitor.sv
// Purpose: checker on the core to bank register link
// Assumes: clk_en dropped by the bench only while the link is idle
// Notes: readback shadows count only after a write was seen
`timescale 1ns/1ps
module sysctl_monitor
  import sysctl_pkg::*;
(
  input wire logic       mclk,
  input wire logic       rst,
  input wire logic       req,
  input wire logic       wr,
  input wire logic [3:0] reg_num,
  input wire logic [2:0] sel,
  input wire word_t      wdata,
  input wire logic       ack,
  input wire word_t      rdata
);
  default clocking @(posedge mclk); endclocking
  default disable iff (rst);
  word_t      ctl_q;
  areas_t     da_q, ia_q;
  logic [2:0] seen_q;
  logic       wc, wa, rd1, rd2;
  assign wc  = req && wr && reg_num == 4'h1;
  assign wa  = ack && wr && reg_num == 4'h2;
  assign rd1 = ack && !wr && reg_num == 4'h1;
  assign rd2 = ack && !wr && reg_num == 4'h2;
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      seen_q <= 3'h0;
    end else if (ack && wc) begin
      ctl_q     <= wdata & 32'h000F_F085;
      seen_q[0] <= 1'b1;
    end else if (wa && sel == 3'h0) begin
      da_q      <= wdata[7:0];
      seen_q[1] <= 1'b1;
    end else if (wa && sel == 3'h1) begin
      ia_q      <= wdata[7:0];
      seen_q[2] <= 1'b1;
    end
  end
  a_ack_after_req:
    assert property (req && !ack |=> ack) else $error("ack late");
  a_ack_one_cycle:
    assert property (ack |=> !ack) else $error("ack held");
  a_req_released:
    assert property (ack |=> !req) else $error("req held");
  a_ctrl_sbz_bits:
    assert property (wc |-> (wdata & 32'hFFF0_0F02) == 32'h0000_0000)
    else $error("reserved zero bits set");
  a_ctrl_sbo_bits:
    assert property (wc |-> wdata[6:3] == 4'hF) else $error("sbo bits");
  a_ctrl_readback:
    assert property (rd1 && seen_q[0] |-> (rdata & 32'h000F_F085) == ctl_q)
    else $error("control readback");
  a_data_areas_back:
    assert property (rd2 && sel == 3'h0 && seen_q[1] |-> rdata[7:0] == da_q)
    else $error("data areas readback");
  a_instr_areas_back:
    assert property (rd2 && sel == 3'h1 && seen_q[2] |-> rdata[7:0] == ia_q)
    else $error("instr areas readback");
  c_ctrl_write: cover property (ack && wc);
  c_data_read: cover property (rd2 && sel == 3'h0);
  c_instr_read: cover property (rd2 && sel == 3'h1);
endmodule

// ### verif/tb_system_control_cache_config_regs.sv
// Purpose: bench for core end and bank joined by the link
// Assumes: clk_en shared by both ends, dropped only while idle
// Notes: reserved control bits masked, their read value is unpredictable
`timescale 1ns/1ps
module tb_system_control_cache_config_regs;
  import sysctl_pkg::*;
  logic        mclk, rst, cmd_valid, cmd_wr, rp, s_mem, s_vec, cmd_ready;
  logic        rsp_valid, iml, ime, dml, dme, lsd, rr, ic, be, dc, po, wb;
  logic [3:0]  cmd_reg;
  logic [2:0]  cmd_sel;
  word_t       cmd_wdata, rsp_data, vb, rd, w, e;
  areas_t      dca, ica;
  logic        en;
  logic [31:0] lf;
  int          bad_count, checks_done;
  sysctl_if link ();
  sysctl_core_end i_sysctl_core_end (.mclk(mclk), .rst(rst), .clk_en(en),
    .cmd_valid(cmd_valid), .cmd_wr(cmd_wr), .cmd_reg(cmd_reg),
    .cmd_sel(cmd_sel), .cmd_wdata(cmd_wdata), .region_programmed(rp),
    .cmd_ready(cmd_ready), .rsp_valid(rsp_valid), .rsp_data(rsp_data),
    .link(link.core));
  sysctl_bank i_sysctl_bank (.mclk(mclk), .rst(rst), .clk_en(en),
    .instr_mem_init_strap(s_mem), .high_vector_strap(s_vec),
    .link(link.bank), .imem_load_mode(iml), .imem_enable(ime),
    .dmem_load_mode(dml), .dmem_enable(dme), .load_state_switch_dis(lsd),
    .round_robin(rr), .vector_base(vb), .icache_on(ic), .big_endian(be),
    .dcache_on(dc), .prot_on(po), .write_buffer_on(wb),
    .data_cachable_areas(dca), .instr_cachable_areas(ica));
  sysctl_monitor i_sysctl_monitor (.mclk(mclk), .rst(rst), .req(link.req),
    .wr(link.wr), .reg_num(link.reg_num), .sel(link.sel),
    .wdata(link.wdata), .ack(link.ack), .rdata(link.rdata));
  function automatic word_t rnd();
    lf = {lf[30:0], 1'b0} ^ (lf[31] ? 32'h0040_0007 : 32'h0000_0000);
    return lf;
  endfunction
  // stored control value: writable fields only, protection needs a region
  function automatic word_t exp_ctrl(input word_t v, input logic p);
    word_t r;
    r = v & 32'h000F_F085;
    r[0] = r[0] & p;
    return r;
  endfunction
  task automatic chk(input logic [63:0] g, x, input string m);
    checks_done++;
    if (g !== x) begin
      bad_count++;
      $display("BAD %0t %s", $time, m);
    end
  endtask
  task automatic end_sim();
    $display("checks %0d bad %0d", checks_done, bad_count);
    if (bad_count == 0 && checks_done > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  task automatic xfer(input logic wt, p, input logic [3:0] r,
                      input logic [2:0] s, input word_t d);
    int n;
    rd = 'x;
    @(posedge mclk);
    {cmd_valid, cmd_wr, cmd_reg, cmd_sel, cmd_wdata, rp} <= {1'b1, wt, r, s, d, p};
    @(posedge mclk);
    cmd_valid <= 1'b0;
    n = 0;
    do begin
      @(posedge mclk);
      #1;
      if (rsp_valid === 1'b1) rd = rsp_data;
      n++;
    end while (cmd_ready !== 1'b1 && n < 10);
    chk(n < 10, 1, "no ready");
  endtask
  // outputs follow stored bits; caches need protection on
  task automatic chk_out(input word_t c, input string m);
    logic [10:0] g, x;
    g = {iml, ime, dml, dme, lsd, rr, ic, be, dc, po, wb};
    x = {c[19:14], c[12] & c[0], c[7], c[2] & c[0], c[0], c[0]};
    chk(g, x, m);
    chk(vb, c[13] ? 32'hFFFF_0000 : 32'h0000_0000, m);
  endtask
  initial begin
    mclk = 1'b0;
    forever #5 mclk = ~mclk;
  end
  initial begin
    repeat (5000) @(posedge mclk);
    bad_count++;
    $display("BAD %0t timeout", $time);
    end_sim();
  end
  initial begin
    {cmd_valid, cmd_wr, cmd_reg, cmd_sel, cmd_wdata, rp} = '0;
    {rst, en} = 2'b11;
    lf = 32'h990c_36c4;
    for (int k = 1; k >= 0; k--) begin
      {s_mem, s_vec, rst} <= {k[0], k[0], 1'b1};
      repeat (2) @(posedge mclk);
      rst <= 1'b0;
      repeat (3) @(posedge mclk);
      #1;
      chk_out({13'h0, k[0], 4'h0, k[0], 13'h0}, "reset");
    end
    $display("test reset done");
    for (int i = 0; i < 24; i++) begin
      w = (i < 2) ? {32{i[0]}} : rnd();
      e = exp_ctrl(w, i != 5);
      xfer(1'b1, i != 5, 4'h1, 3'h0, w);
      chk_out(e, "control outputs");
      xfer(1'b0, 1'b1, 4'h1, 3'h0, rnd());
      chk(rd & 32'h000F_F085, e, "control read");
    end
    $display("test control done");
    // a command offered while the clock enable is low must not be taken
    @(posedge mclk);
    {en, cmd_valid, cmd_wr, cmd_reg, cmd_wdata} <= {2'b01, 1'b1, 4'h1, ~e};
    repeat (4) @(posedge mclk);
    #1;
    chk(link.req, 1'b0, "frozen request");
    chk_out(e, "frozen outputs");
    @(posedge mclk);
    {en, cmd_valid} <= 2'b10;
    repeat (3) @(posedge mclk);
    #1;
    chk_out(e, "after freeze");
    $display("test freeze done");
    for (int i = 0; i < 8; i++) begin
      w = (i < 2) ? 32'h0000_0001 << (7 * i) : rnd();
      e = rnd();
      xfer(1'b1, 1'b1, 4'h2, 3'h0, w);
      xfer(1'b1, 1'b1, 4'h2, 3'h1, e);
      chk({dca, ica}, {w[7:0], e[7:0]}, "areas out");
      xfer(1'b0, 1'b1, 4'h2, 3'h0, rnd());
      chk(rd[7:0], w[7:0], "data areas read");
      xfer(1'b0, 1'b1, 4'h2, 3'h1, rnd());
      chk(rd[7:0], e[7:0], "instr areas read");
      xfer(1'b1, 1'b1, 4'h3, 3'h0, rnd());
      xfer(1'b1, 1'b1, 4'h2, 3'h2, rnd());
      xfer(1'b0, 1'b1, 4'h2, 3'h2, rnd());
      chk({rd, dca, ica}, {32'h0, w[7:0], e[7:0]}, "unmapped");
    end
    $display("test areas done");
    end_sim();
  end
endmodule
